// ### ptpr_cfg.svh
`ifndef PTPR_CFG_SVH
`define PTPR_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PTPR_OFF_MSGCFG2 12'h622
`define PTPR_OFF_DOMVER 12'h624
`define PTPR_OFF_RXLAT 12'h640
`define PTPR_OFF_TXLAT 12'h642
`define PTPR_OFF_ASYM 12'h644
`define PTPR_OFF_LINK 12'h646
`define PTPR_OFF_DREQ_LO 12'h648
`define PTPR_OFF_DREQ_HI 12'h64a
`define PTPR_OFF_SYNC_LO 12'h64c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTPR_VER_MSB 11
`define PTPR_VER_LSB 8
`define PTPR_DOM_MSB 7
`define PTPR_DOM_LSB 0
`define PTPR_DOMEN_BIT 4
`define PTPR_ASYM_SIGN 15
`define PTPR_ASYM_MAG_MSB 14

// ----------------------------------------------------------------------
// Reset and special values
// ----------------------------------------------------------------------
`define PTPR_VER_RST 4'h2
`define PTPR_VER_HOST 4'h1
`define PTPR_DOM_RST 8'h00
`define PTPR_RXLAT_RST 16'h019f
`define PTPR_TXLAT_RST 16'h002d
`define PTPR_WORD_ZERO 16'h0000

`endif

// ### ptpr_pkg.sv
package ptpr_pkg;

  typedef enum logic [3:0] {
    ptpr_msg_sync = 4'h0,
    ptpr_msg_dly_req = 4'h1,
    ptpr_msg_pdly_req = 4'h2,
    ptpr_msg_pdly_resp = 4'h3
  } ptpr_msg_t;

  typedef struct packed {
    logic [1:0] sec;
    logic [29:0] ns;
  } ptpr_stamp_t;

endpackage : ptpr_pkg

// ### ptpr_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ptpr_cfg_if;
  logic [3:0] version;
  logic [7:0] domain;
  logic domain_en;
  logic [15:0] asym;

  modport src (output version, output domain, output domain_en, output asym);
  modport filt (input version, input domain, input domain_en);
  modport corr (input asym);
endinterface : ptpr_cfg_if

`default_nettype wire

// ### ptpr_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptpr_cfg.svh"

module ptpr_filter (
  input wire logic mclk,
  input wire logic rst,
  ptpr_cfg_if.filt cfg,
  input wire logic msg_valid,
  input wire logic [3:0] msg_version,
  input wire logic [7:0] msg_domain,
  input wire logic msg_from_line,
  output logic capture_ff,
  output logic drop_ff,
  output logic fwd_host_ff,
  output logic fwd_peer_ff
);

  logic ver_match;
  logic dom_ok;
  assign ver_match = msg_version == cfg.version;
  // With domain checking off the domain number is not looked at.
  assign dom_ok = !cfg.domain_en || (msg_domain == cfg.domain);

  // ----------------------------------------------------------------------
  // Decision per received message, one-cycle pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      capture_ff <= 1'b0;
      drop_ff <= 1'b0;
      fwd_host_ff <= 1'b0;
      fwd_peer_ff <= 1'b0;
    end else begin
      capture_ff <= msg_valid && ver_match; // RULE1
      drop_ff <= msg_valid && !ver_match; // RULE2
      fwd_host_ff <= msg_valid && ver_match && (cfg.version == `PTPR_VER_HOST) && dom_ok; // RULE3 RULE4 RULE5
      fwd_peer_ff <= msg_valid && ver_match && msg_from_line; // RULE3
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  capture_match_a: assert property (msg_valid && ver_match |=> capture_ff && !drop_ff) // RULE1
    else $error("matching version not captured");
  drop_mismatch_a: assert property (msg_valid && !ver_match |=> drop_ff && !fwd_host_ff && !fwd_peer_ff) // RULE2
    else $error("mismatching version not dropped");
  host_only_v1_a: assert property (fwd_host_ff |-> $past(cfg.version) == `PTPR_VER_HOST) // RULE3
    else $error("host forward with version other than one");
  domain_filter_a: assert property (msg_valid && cfg.domain_en && msg_domain != cfg.domain |=> !fwd_host_ff) // RULE4
    else $error("foreign domain reached host");
  domain_ignore_a: assert property (msg_valid && ver_match && !cfg.domain_en
      && cfg.version == `PTPR_VER_HOST |=> fwd_host_ff) // RULE5
    else $error("message lost with domain check off");

endmodule : ptpr_filter

`default_nettype wire

// ### ptpr_corr.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptpr_cfg.svh"

module ptpr_corr
  import ptpr_pkg::*;
#(
  parameter int unsigned CORR_W = 32
) (
  input wire logic mclk,
  input wire logic rst,
  ptpr_cfg_if.corr cfg,
  input wire logic corr_valid,
  input wire logic corr_ingress,
  input wire ptpr_msg_t corr_type,
  input wire logic [CORR_W-1:0] corr_in,
  output logic corr_out_valid_ff,
  output logic [CORR_W-1:0] corr_out_ff
);

  logic [CORR_W-1:0] mag_w;
  logic do_add;
  logic do_sub;
  logic neg;
  logic [CORR_W-1:0] nxt_corr;

  assign mag_w = CORR_W'(cfg.asym[`PTPR_ASYM_MAG_MSB:0]);
  assign do_add = corr_ingress && (corr_type == ptpr_msg_sync || corr_type == ptpr_msg_pdly_resp);
  assign do_sub = !corr_ingress && (corr_type == ptpr_msg_dly_req || corr_type == ptpr_msg_pdly_req);
  // Sign-magnitude value; subtraction flips the effective sign.
  assign neg = cfg.asym[`PTPR_ASYM_SIGN] ^ do_sub; // RULE8

  always_comb begin
    nxt_corr = corr_in;
    if (do_add || do_sub) begin
      nxt_corr = neg ? corr_in - mag_w : corr_in + mag_w; // RULE9
    end
  end

  // ----------------------------------------------------------------------
  // Registered correction result
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      corr_out_valid_ff <= 1'b0;
      corr_out_ff <= '0;
    end else begin
      corr_out_valid_ff <= corr_valid;
      corr_out_ff <= nxt_corr;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  ingress_add_a: assert property (corr_valid && do_add && !cfg.asym[`PTPR_ASYM_SIGN]
      |=> corr_out_valid_ff && corr_out_ff == $past(corr_in) + $past(mag_w)) // RULE9
    else $error("ingress correction not increased");
  egress_sub_a: assert property (corr_valid && do_sub && !cfg.asym[`PTPR_ASYM_SIGN]
      |=> corr_out_ff == $past(corr_in) - $past(mag_w)) // RULE9
    else $error("egress correction not decreased");
  sign_negative_a: assert property (corr_valid && do_add && cfg.asym[`PTPR_ASYM_SIGN]
      |=> corr_out_ff == $past(corr_in) - $past(mag_w)) // RULE8
    else $error("negative asymmetry applied as positive");
  other_pass_a: assert property (corr_valid && !do_add && !do_sub |=> corr_out_ff == $past(corr_in)) // RULE9
    else $error("unrelated message altered");

endmodule : ptpr_corr

`default_nettype wire

// ### ptpr_regs.sv
// Contract
// RULE1: A received timing message whose version equals the 4-bit version field (reset 2) is captured.
// RULE2: A received timing message whose version differs from the version field is dropped.
// RULE3: Unless the version field is 1, timing messages pass only between line ports 1 and 2, never to port 3.
// RULE4: With domain checking on, messages go to port 3 only when their domain equals the 8-bit domain field (reset 0).
// RULE5: With domain checking off, the message domain number may be ignored in the forwarding decision.
// RULE6: Port 1 receive latency is a 16-bit nanosecond value that resets to 0x019F (415 ns).
// RULE7: Port 1 transmit latency is a 16-bit nanosecond value that resets to 0x002D (45 ns).
// RULE8: Port 1 asymmetry is sign-magnitude, bit 15 set meaning the 15-bit magnitude is negative.
// RULE9: Asymmetry is added to ingress Sync and Pdelay_Resp corrections and subtracted from egress Delay_Req and Pdelay_Req.
// RULE10: Port 1 link delay is a 16-bit nanosecond value that resets to zero.
// RULE11: The low 16 nanosecond bits of the port 1 delay-request egress stamp sit in their own word, reset zero.
// RULE12: The delay-request high word holds nanosecond bits 29 to 16 in its bits 13 to 0.
// RULE13: The delay-request high word holds seconds bits 1 to 0 in its bits 15 to 14, reset zero.
// RULE14: The low nanosecond word of the port 1 Sync egress stamp sits in its own register.
// RULE15: Bit 4 of the message configuration register turns on the domain comparison.
// RULE16: Each egress stamp register loads when a frame of its message type leaves port 1.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ptpr_cfg.svh"

module ptpr_regs
  import ptpr_pkg::*;
#(
  parameter int unsigned CORR_W = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_ff,
  input wire logic rx_msg_valid,
  input wire logic [3:0] rx_msg_version,
  input wire logic [7:0] rx_msg_domain,
  input wire logic rx_from_line,
  output logic rx_capture_ff,
  output logic rx_drop_ff,
  output logic fwd_host_ff,
  output logic fwd_peer_ff,
  input wire logic corr_valid,
  input wire logic corr_ingress,
  input wire ptpr_msg_t corr_type,
  input wire logic [CORR_W-1:0] corr_in,
  output logic corr_out_valid_ff,
  output logic [CORR_W-1:0] corr_out_ff,
  input wire logic tx_stamp_valid,
  input wire ptpr_msg_t tx_stamp_type,
  input wire ptpr_stamp_t tx_stamp,
  output logic [15:0] rx_latency_ff,
  output logic [15:0] tx_latency_ff,
  output logic [15:0] link_delay_ff
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [3:0] version_ff;
  logic [7:0] domain_ff;
  logic domain_en_ff;
  logic [15:0] asym_ff;
  logic [15:0] dreq_lo_ff;
  logic [15:0] dreq_hi_ff;
  logic [15:0] sync_lo_ff;
  logic [15:0] nxt_rdata;
  logic dreq_load;
  logic sync_load;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : addr_hit

  function automatic logic wr_hit(input logic we, input logic [11:0] a, input logic [11:0] off);
    return we && addr_hit(a, off);
  endfunction : wr_hit

  // ----------------------------------------------------------------------
  // Configuration carried to the message logic
  // ----------------------------------------------------------------------
  ptpr_cfg_if cfg_bus ();

  assign cfg_bus.version = version_ff;
  assign cfg_bus.domain = domain_ff;
  assign cfg_bus.domain_en = domain_en_ff;
  assign cfg_bus.asym = asym_ff;

  // ----------------------------------------------------------------------
  // Domain and version register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      version_ff <= `PTPR_VER_RST;
      domain_ff <= `PTPR_DOM_RST;
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_DOMVER)) begin
      version_ff <= reg_wdata[`PTPR_VER_MSB:`PTPR_VER_LSB]; // RULE1
      domain_ff <= reg_wdata[`PTPR_DOM_MSB:`PTPR_DOM_LSB]; // RULE4
    end
  end

  // ----------------------------------------------------------------------
  // Message configuration: only the domain check enable is held here
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      domain_en_ff <= 1'b0;
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_MSGCFG2)) begin
      domain_en_ff <= reg_wdata[`PTPR_DOMEN_BIT]; // RULE15
    end
  end

  // ----------------------------------------------------------------------
  // Port 1 latencies, asymmetry and link delay
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_latency_ff <= `PTPR_RXLAT_RST; // RULE6
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_RXLAT)) begin
      rx_latency_ff <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_latency_ff <= `PTPR_TXLAT_RST; // RULE7
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_TXLAT)) begin
      tx_latency_ff <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      asym_ff <= `PTPR_WORD_ZERO;
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_ASYM)) begin
      asym_ff <= reg_wdata; // RULE8
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_delay_ff <= `PTPR_WORD_ZERO; // RULE10
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_LINK)) begin
      link_delay_ff <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Egress stamps; a frame leaving port 1 wins over a software write
  // ----------------------------------------------------------------------
  assign dreq_load = tx_stamp_valid && (tx_stamp_type == ptpr_msg_dly_req || tx_stamp_type == ptpr_msg_pdly_req);
  assign sync_load = tx_stamp_valid && (tx_stamp_type == ptpr_msg_sync);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dreq_lo_ff <= `PTPR_WORD_ZERO;
    end else if (dreq_load) begin
      dreq_lo_ff <= tx_stamp.ns[15:0]; // RULE11 RULE16
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_DREQ_LO)) begin
      dreq_lo_ff <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dreq_hi_ff <= `PTPR_WORD_ZERO; // RULE13
    end else if (dreq_load) begin
      dreq_hi_ff <= {tx_stamp.sec, tx_stamp.ns[29:16]}; // RULE12 RULE13 RULE16
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_DREQ_HI)) begin
      dreq_hi_ff <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_lo_ff <= `PTPR_WORD_ZERO;
    end else if (sync_load) begin
      sync_lo_ff <= tx_stamp.ns[15:0]; // RULE14 RULE16
    end else if (wr_hit(reg_wr, reg_addr, `PTPR_OFF_SYNC_LO)) begin
      sync_lo_ff <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Read path: data stands in the cycle after the read strobe only
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_rdata = `PTPR_WORD_ZERO;
    case (reg_addr)
      `PTPR_OFF_MSGCFG2: nxt_rdata[`PTPR_DOMEN_BIT] = domain_en_ff;
      `PTPR_OFF_DOMVER: nxt_rdata = {4'h0, version_ff, domain_ff};
      `PTPR_OFF_RXLAT: nxt_rdata = rx_latency_ff;
      `PTPR_OFF_TXLAT: nxt_rdata = tx_latency_ff;
      `PTPR_OFF_ASYM: nxt_rdata = asym_ff;
      `PTPR_OFF_LINK: nxt_rdata = link_delay_ff;
      `PTPR_OFF_DREQ_LO: nxt_rdata = dreq_lo_ff;
      `PTPR_OFF_DREQ_HI: nxt_rdata = dreq_hi_ff;
      `PTPR_OFF_SYNC_LO: nxt_rdata = sync_lo_ff;
      default: nxt_rdata = `PTPR_WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= `PTPR_WORD_ZERO;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= `PTPR_WORD_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // Message filter and correction adjust
  // ----------------------------------------------------------------------
  ptpr_filter u_filter (
    .mclk (mclk),
    .rst (rst),
    .cfg (cfg_bus.filt),
    .msg_valid (rx_msg_valid),
    .msg_version (rx_msg_version),
    .msg_domain (rx_msg_domain),
    .msg_from_line (rx_from_line),
    .capture_ff (rx_capture_ff),
    .drop_ff (rx_drop_ff),
    .fwd_host_ff (fwd_host_ff),
    .fwd_peer_ff (fwd_peer_ff)
  );

  ptpr_corr #(
    .CORR_W (CORR_W)
  ) u_corr (
    .mclk (mclk),
    .rst (rst),
    .cfg (cfg_bus.corr),
    .corr_valid (corr_valid),
    .corr_ingress (corr_ingress),
    .corr_type (corr_type),
    .corr_in (corr_in),
    .corr_out_valid_ff (corr_out_valid_ff),
    .corr_out_ff (corr_out_ff)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  ptpr_stamp_t stamp_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stamp_q <= '0;
    end else begin
      stamp_q <= tx_stamp;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_domver_read;
    reg_rd && addr_hit(reg_addr, `PTPR_OFF_DOMVER);
  endsequence

  sequence s_dreq_frame;
    dreq_load;
  endsequence

  reset_values_a: assert property ($fell(rst) |-> version_ff == `PTPR_VER_RST && domain_ff == `PTPR_DOM_RST
      && !domain_en_ff) // RULE1 RULE4
    else $error("version or domain reset value wrong");
  latency_reset_a: assert property ($fell(rst) |-> rx_latency_ff == `PTPR_RXLAT_RST
      && tx_latency_ff == `PTPR_TXLAT_RST) // RULE6 RULE7
    else $error("latency reset value wrong");
  link_reset_a: assert property ($fell(rst) |-> link_delay_ff == `PTPR_WORD_ZERO
      && dreq_hi_ff == `PTPR_WORD_ZERO) // RULE10 RULE13
    else $error("link delay or stamp reset value wrong");
  domver_read_a: assert property (s_domver_read |=> reg_rdata_ff == {4'h0, $past(version_ff), $past(domain_ff)}) // RULE1
    else $error("domain and version readback wrong");
  domen_write_a: assert property (wr_hit(reg_wr, reg_addr, `PTPR_OFF_MSGCFG2)
      |=> domain_en_ff == $past(reg_wdata[`PTPR_DOMEN_BIT])
      ##1 ($past(wr_hit(reg_wr, reg_addr, `PTPR_OFF_MSGCFG2)) || domain_en_ff == $past(domain_en_ff))) // RULE15
    else $error("domain check enable not held");
  dreq_low_a: assert property (s_dreq_frame |=> dreq_lo_ff == stamp_q.ns[15:0]) // RULE11
    else $error("delay request low word not loaded");
  dreq_high_a: assert property (s_dreq_frame |=> dreq_hi_ff[13:0] == stamp_q.ns[29:16]
      && dreq_hi_ff[15:14] == stamp_q.sec) // RULE12 RULE13
    else $error("delay request high word layout wrong");
  sync_low_a: assert property (sync_load |=> sync_lo_ff == stamp_q.ns[15:0] && $stable(dreq_lo_ff)) // RULE14 RULE16
    else $error("sync stamp not loaded alone");
  stamp_hold_a: assert property (!tx_stamp_valid && !reg_wr |=> $stable(dreq_lo_ff) && $stable(sync_lo_ff)) // RULE16
    else $error("stamp changed without a frame");

endmodule : ptpr_regs

`default_nettype wire

// ### tb_ptp_port_timing_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptpr_cfg.svh"

`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_ptp_port_timing_regs
  import ptpr_pkg::*;
;
  // ----------------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------------
  logic mclk;
  logic rst;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata_ff;
  logic rx_msg_valid;
  logic [3:0] rx_msg_version;
  logic [7:0] rx_msg_domain;
  logic rx_from_line;
  logic rx_capture_ff;
  logic rx_drop_ff;
  logic fwd_host_ff;
  logic fwd_peer_ff;
  logic corr_valid;
  logic corr_ingress;
  ptpr_msg_t corr_type;
  logic [31:0] corr_in;
  logic corr_out_valid_ff;
  logic [31:0] corr_out_ff;
  logic tx_stamp_valid;
  ptpr_msg_t tx_stamp_type;
  ptpr_stamp_t tx_stamp;
  logic [15:0] rx_latency_ff;
  logic [15:0] tx_latency_ff;
  logic [15:0] link_delay_ff;
  int errors;
  int total_checks;
  int cycles;

  ptpr_regs #(.CORR_W(32)) dut_u (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .rx_msg_valid(rx_msg_valid),
    .rx_msg_version(rx_msg_version), .rx_msg_domain(rx_msg_domain), .rx_from_line(rx_from_line),
    .rx_capture_ff(rx_capture_ff), .rx_drop_ff(rx_drop_ff), .fwd_host_ff(fwd_host_ff),
    .fwd_peer_ff(fwd_peer_ff), .corr_valid(corr_valid), .corr_ingress(corr_ingress),
    .corr_type(corr_type), .corr_in(corr_in), .corr_out_valid_ff(corr_out_valid_ff),
    .corr_out_ff(corr_out_ff), .tx_stamp_valid(tx_stamp_valid), .tx_stamp_type(tx_stamp_type),
    .tx_stamp(tx_stamp), .rx_latency_ff(rx_latency_ff), .tx_latency_ff(tx_latency_ff),
    .link_delay_ff(link_delay_ff)
  );

  // ----------------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and port drivers
  // ----------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input string what, input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] v;
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata_ff;
    `CHK(what, exp, v);
  endtask : rdchk

  task automatic stamp(input logic [3:0] ty, input logic [31:0] s);
    @(posedge mclk);
    tx_stamp_valid <= 1'b1;
    tx_stamp_type <= ptpr_msg_t'(ty);
    tx_stamp <= ptpr_stamp_t'(s);
    @(posedge mclk);
    tx_stamp_valid <= 1'b0;
  endtask : stamp

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rdchk("domain version", `PTPR_OFF_DOMVER, 16'h0200);
    rdchk("rx latency", `PTPR_OFF_RXLAT, 16'h019f);
    rdchk("tx latency", `PTPR_OFF_TXLAT, 16'h002d);
    rdchk("asymmetry", `PTPR_OFF_ASYM, 16'h0000);
    rdchk("link delay", `PTPR_OFF_LINK, 16'h0000);
    rdchk("dreq low", `PTPR_OFF_DREQ_LO, 16'h0000);
    rdchk("dreq high", `PTPR_OFF_DREQ_HI, 16'h0000);
    rdchk("sync low", `PTPR_OFF_SYNC_LO, 16'h0000);
    rdchk("msg config", `PTPR_OFF_MSGCFG2, 16'h0000);
    `CHK("rx latency out", 16'h019f, rx_latency_ff);
    `CHK("tx latency out", 16'h002d, tx_latency_ff);
    `CHK("link delay out", 16'h0000, link_delay_ff);
  endtask : t_reset

  task automatic t_regs;
    wr(`PTPR_OFF_RXLAT, 16'h1234);
    wr(`PTPR_OFF_TXLAT, 16'hfedc);
    wr(`PTPR_OFF_LINK, 16'h8001);
    wr(`PTPR_OFF_ASYM, 16'h8005);
    wr(`PTPR_OFF_DOMVER, 16'hffff);
    wr(`PTPR_OFF_MSGCFG2, 16'hffff);
    wr(12'h626, 16'hffff);
    wr(`PTPR_OFF_DREQ_LO, 16'h1357);
    wr(`PTPR_OFF_DREQ_HI, 16'h2468);
    wr(`PTPR_OFF_SYNC_LO, 16'h9abc);
    rdchk("rx latency", `PTPR_OFF_RXLAT, 16'h1234);
    rdchk("tx latency", `PTPR_OFF_TXLAT, 16'hfedc);
    rdchk("link delay", `PTPR_OFF_LINK, 16'h8001);
    rdchk("asymmetry", `PTPR_OFF_ASYM, 16'h8005);
    rdchk("domain version", `PTPR_OFF_DOMVER, 16'h0fff);
    rdchk("msg config", `PTPR_OFF_MSGCFG2, 16'h0010);
    rdchk("unmapped", 12'h626, 16'h0000);
    rdchk("dreq low", `PTPR_OFF_DREQ_LO, 16'h1357);
    rdchk("dreq high", `PTPR_OFF_DREQ_HI, 16'h2468);
    rdchk("sync low", `PTPR_OFF_SYNC_LO, 16'h9abc);
    `CHK("rx latency out", 16'h1234, rx_latency_ff);
    `CHK("tx latency out", 16'hfedc, tx_latency_ff);
    `CHK("link delay out", 16'h8001, link_delay_ff);
  endtask : t_regs

  task automatic t_filter;
    logic [3:0] pv;
    logic den;
    logic host;
    for (int p = 1; p <= 2; p++) begin
      for (int e = 0; e < 2; e++) begin
        pv = p[3:0];
        den = e[0];
        wr(`PTPR_OFF_DOMVER, {4'h0, pv, 8'h5a});
        wr(`PTPR_OFF_MSGCFG2, {11'h000, den, 4'h0});
        for (int i = 0; i < 8; i++) begin
          @(posedge mclk);
          rx_msg_valid <= 1'b1;
          rx_msg_version <= i[0] ? pv : pv + 4'h4;
          rx_msg_domain <= i[1] ? 8'h5a : 8'h5b;
          rx_from_line <= i[2];
          @(posedge mclk);
          rx_msg_valid <= 1'b0;
          #1;
          host = i[0] && pv == 4'h1 && (!den || i[1]);
          `CHK("capture", i[0], rx_capture_ff);
          `CHK("drop", !i[0], rx_drop_ff);
          `CHK("to host", host, fwd_host_ff);
          `CHK("to peer", i[0] && i[2], fwd_peer_ff);
        end
      end
    end
  endtask : t_filter

  task automatic t_corr;
    logic [15:0] a;
    logic [31:0] adj;
    logic [31:0] exp;
    for (int s = 0; s < 2; s++) begin
      a = s ? 16'h8007 : 16'h0007;
      wr(`PTPR_OFF_ASYM, a);
      adj = a[15] ? 32'h0000_0000 - {17'h0_0000, a[14:0]} : {17'h0_0000, a[14:0]};
      for (int t = 0; t < 8; t++) begin
        @(posedge mclk);
        corr_valid <= 1'b1;
        corr_ingress <= t[2];
        corr_type <= ptpr_msg_t'({2'b00, t[1:0]});
        corr_in <= 32'h0000_1000;
        @(posedge mclk);
        corr_valid <= 1'b0;
        #1;
        exp = 32'h0000_1000;
        if (t[2] && (t[1:0] == 2'd0 || t[1:0] == 2'd3)) begin
          exp = exp + adj;
        end else if (!t[2] && (t[1:0] == 2'd1 || t[1:0] == 2'd2)) begin
          exp = exp - adj;
        end
        `CHK("corr valid", 1'b1, corr_out_valid_ff);
        `CHK("corr value", exp, corr_out_ff);
      end
    end
  endtask : t_corr

  task automatic t_stamps;
    stamp(4'h1, 32'h8123_4567);
    rdchk("dreq low", `PTPR_OFF_DREQ_LO, 16'h4567);
    rdchk("dreq high", `PTPR_OFF_DREQ_HI, {2'b10, 14'h0123});
    stamp(4'h2, 32'h7edc_ba98);
    rdchk("pdreq low", `PTPR_OFF_DREQ_LO, 16'hba98);
    rdchk("pdreq high", `PTPR_OFF_DREQ_HI, {2'b01, 14'h3edc});
    stamp(4'h0, 32'h5555_aaaa);
    rdchk("sync low", `PTPR_OFF_SYNC_LO, 16'haaaa);
    rdchk("dreq kept", `PTPR_OFF_DREQ_LO, 16'hba98);
    stamp(4'h3, 32'h1111_2222);
    rdchk("sync kept", `PTPR_OFF_SYNC_LO, 16'haaaa);
    rdchk("dreq held", `PTPR_OFF_DREQ_HI, {2'b01, 14'h3edc});
  endtask : t_stamps

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_msg_valid = 1'b0;
    rx_msg_version = 4'h0;
    rx_msg_domain = 8'h00;
    rx_from_line = 1'b0;
    corr_valid = 1'b0;
    corr_ingress = 1'b0;
    corr_type = ptpr_msg_sync;
    corr_in = 32'h0000_0000;
    tx_stamp_valid = 1'b0;
    tx_stamp_type = ptpr_msg_sync;
    tx_stamp = '0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_filter();
    t_corr();
    t_stamps();
    print_verdict();
  end
endmodule : tb_ptp_port_timing_regs

`default_nettype wire
